// *** design/sram_host_pkg.sv ***
package sram_host_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;

    // Clock period and the printed cycle times of the memory.
    localparam int CLK_PERIOD_NS = 5;
    localparam int READ_CYCLE_NS = 70;
    localparam int WRITE_PULSE_NS = 50;
    localparam int DATA_OVERLAP_NS = 30;
    localparam int WRITE_CYCLE_NS = 70;
    localparam int BUS_TURN_NS = 30;
    localparam int RECOVERY_NS = 70;

    // Least times round up to whole cycles.
    localparam int READ_CYCLES = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_OVERLAP_CYCLES = (DATA_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYCLES = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 5;

    // Pin levels when the chip is idle.
    localparam logic [1:0] LANES_OFF = 2'h3;

    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic write_strobe_n;
        logic output_strobe_n;
        logic low_lane_enable_n;
        logic high_lane_enable_n;
    } ctrl_pins_t;

    // Idle pin levels: deselected by both selects, with strobes and lanes off.
    localparam ctrl_pins_t CTRL_IDLE = '{select_active_low: 1'b1, select_active_high: 1'b0, default: 1'b1};

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] lanes;
    } request_t;

endpackage : sram_host_pkg

// *** design/sram_host_ctrl.sv ***
// Functional notes
// - Write happens only while strobe, both selects and a lane enable coincide low/high.
// - Write ends at the first of selects, lanes or strobe going inactive.
// - Host must not drive data pins while the memory drives them.
// - First select active low, second select active high.
// - Lane enables are active low; both high means standby.
// - Retention may be entered right after deselect, with no delay.
module sram_host_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // User request port
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire sram_host_pkg::request_t i_req,
    input wire logic i_retain,
    // User answer port
    output logic o_rdata_valid,
    output logic [sram_host_pkg::DATA_W-1:0] o_rdata,
    output logic o_retained,
    // Memory pins
    output logic [sram_host_pkg::ADDR_W-1:0] o_addr,
    output sram_host_pkg::ctrl_pins_t o_ctrl,
    input wire logic [sram_host_pkg::DATA_W-1:0] i_data,
    output logic [sram_host_pkg::DATA_W-1:0] o_data,
    output logic [sram_host_pkg::DATA_W-1:0] o_data_oe
);

    // Seven states in a three-bit code, so one code is illegal.
    typedef enum logic [2:0] {IDLE, READ, WRITE, WRITE_END, TURN, RETAIN, RECOVER} state_t;

    state_t state;
    logic [sram_host_pkg::CNT_W-1:0] cnt;
    logic [1:0] lanes;
    logic drive;

    // Last count of each phase. A phase of N cycles counts from 0 to N-1, so each limit
    // is one less than the cycle count that the package gives.
    localparam logic [sram_host_pkg::CNT_W-1:0] READ_LAST =
        sram_host_pkg::CNT_W'(sram_host_pkg::READ_CYCLES - 1);
    localparam logic [sram_host_pkg::CNT_W-1:0] WP_LAST =
        sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_PULSE_CYCLES - 1);
    localparam logic [sram_host_pkg::CNT_W-1:0] WC_LAST =
        sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_CYCLES - 1);
    localparam logic [sram_host_pkg::CNT_W-1:0] TURN_LAST =
        sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYCLES - 1);
    localparam logic [sram_host_pkg::CNT_W-1:0] REC_LAST =
        sram_host_pkg::CNT_W'(sram_host_pkg::RECOVERY_CYCLES - 1);
    // The data enable is registered, so it is raised one count before the overlap window
    // in order to stand on the pins for the whole window.
    localparam logic [sram_host_pkg::CNT_W-1:0] DW_START =
        sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_PULSE_CYCLES - sram_host_pkg::DATA_OVERLAP_CYCLES - 1);

    // A request is only taken between cycles, so address and lanes never move mid cycle.
    // Ready is combinational, so a request waiting in idle is taken on the first edge.
    assign o_req_ready = (state == IDLE) && !i_retain;

    // Sequencer.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= IDLE;
            cnt <= '0;
        end else begin
            unique case (state)
                IDLE: begin
                    cnt <= '0;
                    // Retention wins over a waiting request, which stays pending until the
                    // recovery time has run out.
                    if (i_retain) begin
                        state <= RETAIN;
                    end else if (i_req_valid) begin
                        state <= i_req.write ? WRITE : READ;
                    end
                end
                READ: begin
                    // The strobes stand for the full read cycle time and data is taken on the last count.
                    cnt <= cnt + 1'b1;
                    if (cnt == READ_LAST) begin
                        state <= TURN;
                        cnt <= '0;
                    end
                end
                WRITE: begin
                    // The strobe rises on the edge that leaves this state.
                    cnt <= cnt + 1'b1;
                    if (cnt == WP_LAST) begin
                        state <= WRITE_END;
                    end
                end
                WRITE_END: begin
                    // No new cycle starts until the write cycle time is complete, so the address
                    // cannot change before the memory has closed the cycle.
                    cnt <= cnt + 1'b1;
                    if (cnt >= WC_LAST) begin
                        state <= IDLE;
                        cnt <= '0;
                    end
                end
                TURN: begin
                    // The memory may keep driving for a while after its strobe rises.
                    // The count covers the longest time that the memory takes to release its pins.
                    cnt <= cnt + 1'b1;
                    if (cnt == TURN_LAST) begin
                        state <= IDLE;
                        cnt <= '0;
                    end
                end
                RETAIN: begin
                    // Pins stay deselected, so the supply may be lowered from the next cycle on.
                    cnt <= '0;
                    if (!i_retain) begin
                        state <= RECOVER;
                    end
                end
                RECOVER: begin
                    // The memory needs a full read cycle time after retention before it is used.
                    cnt <= cnt + 1'b1;
                    if (cnt == REC_LAST) begin
                        state <= IDLE;
                        cnt <= '0;
                    end
                end
                default: begin
                    // The illegal code returns to idle.
                    state <= IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    // Address, lanes and write data latch once at the start of a cycle.
    // Write data is latched with the address, so it stays stable through the whole pulse.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_addr <= '0;
            lanes <= sram_host_pkg::LANES_OFF;
            o_data <= '0;
        end else if (o_req_ready && i_req_valid) begin
            o_addr <= i_req.addr;
            lanes <= i_req.lanes;
            o_data <= i_req.wdata;
        end
    end

    // Control pins: selects and lanes go active together with the write strobe, so the
    // memory never turns its outputs on during a write.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ctrl <= sram_host_pkg::CTRL_IDLE;
        end else begin
            o_ctrl.write_strobe_n <= 1'b1;
            o_ctrl.output_strobe_n <= 1'b1;
            o_ctrl.select_active_low <= 1'b1;
            o_ctrl.select_active_high <= 1'b0;
            o_ctrl.low_lane_enable_n <= 1'b1;
            o_ctrl.high_lane_enable_n <= 1'b1;
            // A cycle starts on the take edge itself, so selects, lanes and strobe leave
            // their idle levels on the same edge as the address.
            if ((state == IDLE && i_req_valid && !i_retain) ||
                (state == READ && cnt != READ_LAST) ||
                (state == WRITE && cnt != WP_LAST)) begin
                o_ctrl.select_active_low <= 1'b0;
                o_ctrl.select_active_high <= 1'b1;
                o_ctrl.low_lane_enable_n <= (state == IDLE) ? ~i_req.lanes[0] : ~lanes[0];
                o_ctrl.high_lane_enable_n <= (state == IDLE) ? ~i_req.lanes[1] : ~lanes[1];
                if ((state == IDLE) ? i_req.write : (state == WRITE)) begin
                    o_ctrl.write_strobe_n <= 1'b0;
                end else begin
                    o_ctrl.output_strobe_n <= 1'b0;
                end
            end
            // All strobes rise together, ending the write on the strobe edge.
        end
    end

    // Data pins are driven only in the last part of the write pulse, after the
    // memory has certainly released the bus, and only on enabled lanes. The enable
    // drops on the same edge as the strobe; holding it one cycle longer would leave
    // the host driving pins that no longer belong to a write cycle.
    assign drive = (state == WRITE) && (cnt >= DW_START) && (cnt != WP_LAST);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data_oe <= '0;
        end else begin
            o_data_oe <= drive ? {{sram_host_pkg::LANE_W{lanes[1]}}, {sram_host_pkg::LANE_W{lanes[0]}}} : '0;
        end
    end

    // Read data is captured on the last cycle of the read, then the strobes rise.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
            o_rdata_valid <= 1'b0;
        end else begin
            o_rdata_valid <= 1'b0;
            if (state == READ && cnt == READ_LAST) begin
                // A lane that is not enabled floats at the memory, so it reads as zero.
                o_rdata[7:0] <= lanes[0] ? i_data[7:0] : 8'h00;
                o_rdata[15:8] <= lanes[1] ? i_data[15:8] : 8'h00;
                o_rdata_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_retained <= 1'b0;
        end else begin
            // The flag is registered, so it lags the state by one cycle.
            o_retained <= (state == RETAIN);
        end
    end

endmodule : sram_host_ctrl

// *** test/sram_model.sv ***
module sram_model (
    input wire logic i_clk,
    input wire logic [17:0] i_addr,
    input wire sram_host_pkg::ctrl_pins_t i_ctrl,
    input wire logic [15:0] i_data,
    input wire logic [15:0] i_oe,
    output logic [15:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [17:0]];
    logic [15:0] last = 16'h0;
    logic sel, rd;
    logic [1:0] ln;
    assign sel = !i_ctrl.select_active_low && i_ctrl.select_active_high;
    assign ln = ~{i_ctrl.high_lane_enable_n, i_ctrl.low_lane_enable_n};
    assign rd = sel && i_ctrl.write_strobe_n && !i_ctrl.output_strobe_n;
    always @(posedge i_clk) begin
        for (int b = 0; b < 2; b++) begin
            if (sel && !i_ctrl.write_strobe_n && ln[b] && i_oe[b*8]) begin
                mem[i_addr][b*8+:8] <= i_data[b*8+:8];
            end
        end
        last <= o_data;
    end
    // Released lanes show a changing pattern so stale data cannot pass as a read.
    always @* begin
        for (int b = 0; b < 2; b++) begin
            o_data[b*8+:8] = (rd && ln[b]) ? mem[i_addr][b*8+:8] : ~last[b*8+:8];
        end
    end
endmodule : sram_model

// *** test/sram_host_ctrl_chk.sv ***
module sram_host_ctrl_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire sram_host_pkg::request_t i_req,
    input wire logic o_rdata_valid,
    input wire logic [15:0] o_rdata,
    input wire logic o_retained,
    input wire sram_host_pkg::ctrl_pins_t o_ctrl,
    input wire logic [15:0] i_data,
    input wire logic [15:0] o_data_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire tk = i_req_valid && o_req_ready;
    wire wr_n = o_ctrl.write_strobe_n;
    wire rd_n = o_ctrl.output_strobe_n;
    wire lo_n = o_ctrl.low_lane_enable_n;
    wire hi_n = o_ctrl.high_lane_enable_n;
    a_write_sel: assert property (!wr_n |-> !o_ctrl.select_active_low && o_ctrl.select_active_high && rd_n)
        else $error("write strobe misplaced");
    a_host_quiet: assert property (|o_data_oe |-> !wr_n && rd_n)
        else $error("host drives outside write");
    a_read_walk: assert property (tk && !i_req.write |=> !rd_n [*8] ##1 !rd_n [*6] ##1 o_rdata_valid)
        else $error("read walk wrong");
    a_pulse_len: assert property (tk && i_req.write |=> !wr_n [*8] ##1 !wr_n [*2] ##1 wr_n)
        else $error("write pulse wrong");
    a_end_together: assert property ($rose(wr_n) |-> o_ctrl.select_active_low && o_data_oe == 16'h0)
        else $error("write end split");
    a_lane_gate: assert property ((o_data_oe[0] |-> !lo_n) and (o_data_oe[8] |-> !hi_n))
        else $error("lane drive ungated");
    a_rdata_mask: assert property (o_rdata_valid |-> o_rdata == ($past(i_data) & {{8{!$past(hi_n)}}, {8{!$past(lo_n)}}}))
        else $error("read data mask wrong");
    a_retain_idle: assert property (o_retained |-> o_ctrl.select_active_low && !o_ctrl.select_active_high && wr_n)
        else $error("retention not deselected");
endmodule : sram_host_ctrl_chk

// *** test/test_sram_host_ctrl.sv ***
module test_sram_host_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst = 1, i_req_valid = 0, i_retain = 0, o_req_ready, o_rdata_valid, o_retained;
    sram_host_pkg::request_t i_req = '0;
    sram_host_pkg::ctrl_pins_t o_ctrl;
    logic [15:0] o_rdata, o_data, o_data_oe, mdl_q, pin;
    logic [17:0] o_addr;
    logic [15:0] sh [logic [17:0]];
    int fail_count = 0, tests_run = 0, seed = 38808;
    always #2.5 i_clk = ~i_clk;
    assign pin = (o_data_oe & o_data) | (~o_data_oe & mdl_q);
    sram_host_ctrl u_sram_host_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .i_retain(i_retain), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
        .o_retained(o_retained), .o_addr(o_addr), .o_ctrl(o_ctrl), .i_data(pin), .o_data(o_data), .o_data_oe(o_data_oe));
    sram_model u_sram_model (.i_clk(i_clk), .i_addr(o_addr), .i_ctrl(o_ctrl), .i_data(pin), .i_oe(o_data_oe), .o_data(mdl_q));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic wait_hi(input int which);
        int n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (((which == 2) ? o_retained : (which == 1) ? o_rdata_valid : o_req_ready) !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            wrap_up();
        end
    endtask : wait_hi
    // The request is held unchanged until the take edge, then the shadow is updated for a write or the read data is checked.
    task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
        logic [15:0] e;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req <= '{w, a, d, l};
        wait_hi(1'b0);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        e = {l[1] ? sh[a][15:8] : 8'h0, l[0] ? sh[a][7:0] : 8'h0};
        if (w) begin
            sh[a] = {l[1] ? d[15:8] : sh[a][15:8], l[0] ? d[7:0] : sh[a][7:0]};
        end else begin
            wait_hi(1'b1);
            check("read data", o_rdata, e);
        end
    endtask : xfer
    initial begin
        logic [17:0] a;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            sh[(i == 8) ? 18'h3ffff : 18'(i)] = 16'h0;
            xfer(1'b1, (i == 8) ? 18'h3ffff : 18'(i), 16'(i * 16'h1111 + 16'h0f0f), 2'h3);
        end
        xfer(1'b1, 18'h2, 16'hbeef, 2'h1);
        xfer(1'b0, 18'h2, 16'h0, 2'h3);
        xfer(1'b1, 18'h2, 16'h5a77, 2'h2);
        xfer(1'b0, 18'h2, 16'h0, 2'h1);
        xfer(1'b0, 18'h2, 16'h0, 2'h0);
        $display("test lanes done");
        repeat (40) begin
            a = ($random(seed) & 1) ? 18'h3ffff : 18'($random(seed) & 7);
            xfer(1'($random(seed)), a, 16'($random(seed)), 2'($random(seed)));
        end
        $display("test random done");
        @(posedge i_clk);
        i_retain <= 1'b1;
        wait_hi(2);
        check("retained", 16'(o_retained), 16'h1);
        check("select", 16'({o_ctrl.select_active_low, o_ctrl.select_active_high}), 16'h2);
        @(posedge i_clk);
        i_retain <= 1'b0;
        xfer(1'b0, 18'h3ffff, 16'h0, 2'h3);
        $display("test retain done");
        wrap_up();
    end
endmodule : test_sram_host_ctrl
bind sram_host_ctrl sram_host_ctrl_chk u_chk (.*);
